// *** include/tuner_bias_pkg.sv ***
// types shared by the bias controller
package tuner_bias_pkg;
  typedef enum logic [3:0] {
    MODE_SHUTDOWN = 4'h1,
    MODE_STARTUP  = 4'h2,
    MODE_ACTIVE   = 4'h4,
    MODE_LOWPOWER = 4'h8
  } mode_type;

  typedef struct packed {
    logic [7:0] code0;
    logic [7:0] code1;
    logic [7:0] code2;
    logic [7:0] code3;
    logic [7:0] code4;
    logic [7:0] code5;
  } codes_type;

  typedef struct packed {
    logic [3:0] boostLevel;
    logic [5:0] enableMask;
    logic [1:0] powerSelect;
    codes_type  codes;
  } regs_type;

  typedef struct packed {
    logic [2:0]  rail;
    logic [2:0]  sclk;
    logic [2:0]  csel;
    logic [1:0]  sdata;
    logic [31:0] shift;
    logic [6:0]  count;
    logic        overflow;
    logic [15:0] wakeCount;
    logic [7:0]  boostDiv;
    logic [3:0]  lfsr;
    mode_type    mode;
    regs_type    regs;
    logic        boostRun;
    logic        boostClk;
    logic [5:0]  driveOn;
    codes_type   outCodes;
    logic [1:0]  powerState;
    logic [1:0]  cmp;
  } state_type;
endpackage

// *** include/tuner_bias_regs.svh ***
// register offsets, field positions, reset values and timing counts
// Notes on behaviour
// - io rail rising enters startup and resets every register to default
// - the same reset clears all serial interface state
// - reset refires only after io rail went low; no brown-out detection
// - power state reads startup after reset then moves to active alone
// - boost level defaults to 1011 and all six enables default to zero
// - after reset every high voltage output stands high impedance
// - io rail low means shutdown, all blocks off, registers discarded
// - shutdown to active completes within 300 us, typically 180 us
// - with io rail applied device starts alone and waits in active
// - boost on while rail below 4-bit reference, off once above it
// - boost switching clock averages 2 MHz, spread from 0.8 to 4 MHz; code spreads half periods over 19 to 33 core cycles only
// - output volts equal code over 255 times 24 V times two
// - in shutdown every high voltage output is high impedance
// - each frame is judged alone as bus command, 30-bit or 32-bit
// - three-wire port is write only with no read-back
// - chip select change before full length drops every bit of frame
// - data arrives msb first and is sampled on rising clock edges
// - a three-wire command is committed only on chip select falling
// - frame length is rising edges while select high; only 30 or 32
// - low power keeps serial alive and registers, outputs and boost off
// - power state command to startup from active or low power resets all
`ifndef TUNER_BIAS_REGS_SVH
`define TUNER_BIAS_REGS_SVH
`define ADDR_DAC_CB      5'h00
`define ADDR_DAC_BA      5'h01
`define ADDR_DAC_FE      5'h02
`define ADDR_DAC_ED      5'h03
`define ADDR_CONTROL     5'h04
`define RST_BOOST_LEVEL  4'hb
`define RST_ENABLE_MASK  6'h00
`define PWR_ACTIVE       2'h0
`define PWR_STARTUP      2'h1
`define PWR_LOW          2'h2
`define FRAME_SHORT      6'h1e
`define FRAME_LONG       6'h20
`define HEADER_LONG      3'h6
`define DEVICE_ID_FIELD  8'h6d  // arbitrary device match value
`define WAKE_TYPICAL_US  180
`define WAKE_MAX_US      300
`define CLOCK_MHZ        100
`define BOOST_AVG_KHZ    2000
`define BOOST_MIN_KHZ    800
`define BOOST_MAX_KHZ    4000
`endif

// *** tb/serial_host_model.sv ***
// host end of the three-wire link, frames sent msb first
`timescale 1ns/1ps
module serial_host_model (
  output logic serialClk,
  output logic chipSelect,
  output logic serialData
);
  // clock rests low and select low between frames
  initial begin
    serialClk = 1'b0;
    chipSelect = 1'b0;
    serialData = 1'b0;
  end
  // sends the low n bits of w; select drops early after c bits
  task automatic send(input logic [32:0] w, input int n, input int c);
    #3 chipSelect = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      serialData = w[i];
      #40 serialClk = 1'b1;
      #40 serialClk = 1'b0;
      if (n - i == c) chipSelect = 1'b0;
    end
    #20 chipSelect = 1'b0;
    serialData = ~serialData; // released line shows no stale level
    #200;
  endtask
endmodule // serial_host_model

// *** tb/tuner_bias_checker.sv ***
// port assertions for the bias controller
`timescale 1ns/1ps
module tuner_bias_checker #(
  parameter int WAKE_CYCLES = 50
) (
  input logic                      core_clk,
  input logic                      rst,
  input logic                      ioRailLevel,
  input logic                      chipSelect,
  input logic                      railBelowReference,
  input logic                      boostEnable,
  input logic                      boostSwitchClk,
  input logic [3:0]                boostLevelCode,
  input logic [5:0]                outputDriveEnable,
  input tuner_bias_pkg::codes_type outputCodes,
  input logic [1:0]                powerStateCommand
);
  localparam int WAKE_LIM = WAKE_CYCLES + 12;
  logic [7:0] halfCnt_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // cycles since the switching clock last toggled while boosting
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) halfCnt_q <= 8'h00;
    else if (!boostEnable || $changed(boostSwitchClk)) halfCnt_q <= 8'h00;
    else halfCnt_q <= halfCnt_q + 8'h01;
  end
  // rail rising, and select held high with the rail up
  sequence rail_up_s;
    $rose(ioRailLevel);
  endsequence
  sequence cs_idle_s;
    (chipSelect && ioRailLevel) [*8];
  endsequence
  rail_low_a:
    assert property (!ioRailLevel [*6] |-> boostLevelCode == 4'hb &&
      outputDriveEnable == 6'h00 && outputCodes == '0 && !boostEnable)
    else $error("registers kept with io rail low");
  startup_hold_a:
    assert property (rail_up_s |-> (powerStateCommand == 2'h1) [*8])
    else $error("startup state skipped");
  wake_bound_a:
    assert property (rail_up_s |-> ##[1:WAKE_LIM]
      (powerStateCommand == 2'h0 || !ioRailLevel))
    else $error("active state not reached in time");
  boost_off_a:
    assert property (!railBelowReference [*5] |-> !boostEnable)
    else $error("boost runs above reference");
  low_quiet_a:
    assert property ((powerStateCommand == 2'h2) [*2] |-> !boostEnable &&
      outputDriveEnable == 6'h00)
    else $error("boost or drive on in low power");
  startup_quiet_a:
    assert property ((powerStateCommand == 2'h1) [*2] |->
      outputDriveEnable == 6'h00 && outputCodes == '0)
    else $error("output driven in startup");
  commit_fall_a:
    assert property (cs_idle_s |-> $stable(boostLevelCode) &&
      $stable(outputCodes))
    else $error("write landed while select high");
  switch_period_a:
    assert property (boostEnable |-> halfCnt_q <= 8'h20)
    else $error("switching half period too long");
endmodule // tuner_bias_checker
bind tuner_bias_power_and_serial_ctrl tuner_bias_checker #(
  .WAKE_CYCLES(WAKE_CYCLES)) tuner_bias_checker_inst (
  .core_clk(core_clk), .rst(rst), .ioRailLevel(ioRailLevel),
  .chipSelect(chipSelect), .railBelowReference(railBelowReference),
  .boostEnable(boostEnable), .boostSwitchClk(boostSwitchClk),
  .boostLevelCode(boostLevelCode), .outputCodes(outputCodes),
  .outputDriveEnable(outputDriveEnable),
  .powerStateCommand(powerStateCommand));

// *** tb/tuner_bias_power_and_serial_ctrl_tb.sv ***
// self-checking bench for the bias controller
`timescale 1ns/1ps
`include "tuner_bias_regs.svh"
module tuner_bias_power_and_serial_ctrl_tb;
  localparam int WAKE = 50;
  logic                      core_clk, rst, ioRailLevel, railBelowReference;
  logic                      serialClk, chipSelect, serialData, pinCmp;
  logic                      boostEnable, boostSwitchClk;
  logic [3:0]                boostLevelCode, expLevel;
  logic [5:0]                outputDriveEnable, expMask;
  logic [1:0]                powerStateCommand, expPwr;
  logic [16:0]               seed;
  logic [4:0]                a;
  tuner_bias_pkg::codes_type outputCodes, expCodes;
  int                        errors, n_checks;
  int                        togs;
  logic                      prevClk;

  tuner_bias_power_and_serial_ctrl #(.WAKE_CYCLES(WAKE))
    tuner_bias_power_and_serial_ctrl_inst (
    .core_clk(core_clk), .rst(rst), .ioRailLevel(ioRailLevel),
    .serialClk(serialClk), .chipSelect(chipSelect), .serialData(serialData),
    .railBelowReference(railBelowReference), .boostEnable(boostEnable),
    .boostSwitchClk(boostSwitchClk), .boostLevelCode(boostLevelCode),
    .outputDriveEnable(outputDriveEnable), .outputCodes(outputCodes),
    .powerStateCommand(powerStateCommand));
  serial_host_model serial_host_model_inst (.serialClk(serialClk),
    .chipSelect(chipSelect), .serialData(serialData));

  // 100 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // next value of the bench's 17-bit random source
  function automatic logic [16:0] lfsr_next(logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction
  // comparator wanders at random unless pinned high
  always @(posedge core_clk) begin
    seed <= lfsr_next(seed);
    if (pinCmp || seed[3:0] == 4'h0) railBelowReference <= #1 pinCmp | seed[4];
  end
  // write frame with the fixed device field
  function automatic logic [32:0] frm(logic [4:0] ad, logic [15:0] d);
    return {4'h0, `DEVICE_ID_FIELD, d, ad};
  endfunction
  function automatic void expect_reset();
    expCodes = '0;
    expLevel = 4'hb;
    expMask = 6'h00;
    expPwr = 2'h1;
  endfunction
  function automatic void expect_write(logic [4:0] ad, logic [15:0] d);
    case (ad)
      5'h00: expCodes.code2 = d[7:0];
      5'h01: {expCodes.code1, expCodes.code0} = d;
      5'h02: expCodes.code5 = d[7:0];
      5'h03: {expCodes.code4, expCodes.code3} = d;
      5'h04: {expPwr, expLevel, expMask} = {d[13:8], d[5:0]};
      default: ;
    endcase
    if (expPwr == 2'h1) expect_reset();
  endfunction
  task automatic chk(logic [47:0] got, logic [47:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // compares every register output with the expected set
  task automatic chk_all();
    // outputs are read clear of the clock edge that launches them
    #2;
    chk(outputCodes, expCodes);
    chk(48'(boostLevelCode), 48'(expLevel));
    chk(48'(powerStateCommand), 48'(expPwr));
    chk(48'(outputDriveEnable),
        48'(expPwr == 2'h0 ? expMask : 6'h00));
  endtask
  task automatic wr(logic [4:0] ad, logic [15:0] d, bit lng);
    // long frames carry header bits 11 above the write bit
    serial_host_model_inst.send(frm(ad, d) | {1'b0, lng, lng, 30'h0},
                                lng ? 32 : 30, 0);
    expect_write(ad, d);
    chk_all();
  endtask
  task automatic bad(logic [32:0] f, int n, int c);
    serial_host_model_inst.send(f, n, c);
    chk_all();
  endtask
  task automatic power_up();
    @(posedge core_clk) #1 ioRailLevel = 1'b1;
    repeat (10) @(posedge core_clk);
    chk_all();
    repeat (WAKE + 20) @(posedge core_clk);
    expPwr = 2'h0;
    chk_all();
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // main sequence
  initial begin
    {rst, ioRailLevel, railBelowReference, pinCmp} = 4'h8;
    seed = 17'h1717b; // 94587
    errors = 0;
    n_checks = 0;
    expect_reset();
    repeat (10) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge core_clk);
    chk_all();
    power_up();
    for (int k = 0; k < 5; k++) wr(5'(k), 16'h0fff, k[0]);
    for (int i = 0; i < 20; i++) begin
      a = 5'(seed[2:0] % 3'h5);
      wr(a, seed[16:1] & (a == 5'h04 ? 16'hcfff : 16'hffff),
         seed[0]);
    end
    bad(frm(5'h01, 16'h5a5a) | 33'h020000000, 30, 0);
    bad(frm(5'h01, 16'h5a5a) ^ 33'h000200000, 30, 0);
    bad(frm(5'h01, 16'h5a5a) | 33'h080000000, 32, 0);
    bad(frm(5'h01, 16'h5a5a), 29, 0);
    bad(frm(5'h01, 16'h5a5a), 31, 0);
    bad(frm(5'h01, 16'h5a5a), 30, 15);
    bad(frm(5'h1f, 16'h5a5a), 30, 0);
    pinCmp = 1'b1;
    wr(5'h04, 16'h2b15, 0);
    chk(48'(boostEnable), 48'h0);
    wr(5'h00, 16'h0077, 1);
    wr(5'h04, 16'h0b15, 0);
    chk(48'(boostEnable), 48'h1);
    togs = 0;
    prevClk = boostSwitchClk;
    // switching clock toggles over 200 cycles, spread 0.8 to 4 MHz
    repeat (200) begin
      @(posedge core_clk) #2;
      if (boostSwitchClk !== prevClk) togs++;
      prevClk = boostSwitchClk;
    end
    chk(48'(togs >= 3 && togs <= 17), 48'h1);
    pinCmp = 1'b0;
    wr(5'h04, 16'h1000, 1);
    repeat (WAKE + 20) @(posedge core_clk);
    expPwr = 2'h0;
    chk_all();
    wr(5'h03, 16'h8001, 0);
    @(posedge core_clk) #1 ioRailLevel = 1'b0;
    repeat (8) @(posedge core_clk);
    expect_reset();
    chk_all();
    power_up();
    wrap_up();
  end
  // watchdog cuts a hang short
  initial begin
    #500000;
    errors++;
    wrap_up();
  end
endmodule // tuner_bias_power_and_serial_ctrl_tb

// *** verilog/tuner_bias_power_and_serial_ctrl.sv ***
// power sequencing, boost control and three-wire write port of the biaser
`timescale 1ns/1ps
`include "tuner_bias_regs.svh"
module tuner_bias_power_and_serial_ctrl #(
  parameter int WAKE_CYCLES = `WAKE_TYPICAL_US * `CLOCK_MHZ
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   ioRailLevel,
  input  wire logic                   serialClk,
  input  wire logic                   chipSelect,
  input  wire logic                   serialData,
  input  wire logic                   railBelowReference,
  output logic                        boostEnable,
  output logic                        boostSwitchClk,
  output logic [3:0]                  boostLevelCode,
  output logic [5:0]                  outputDriveEnable,
  output tuner_bias_pkg::codes_type   outputCodes,
  output logic [1:0]                  powerStateCommand
);
  // wake delay must sit below the longest permitted startup time
  localparam int WAKE_LIMIT = `WAKE_MAX_US * `CLOCK_MHZ;
  localparam int WAKE_USED  = (WAKE_CYCLES < WAKE_LIMIT) ?
                              WAKE_CYCLES : WAKE_LIMIT;
  localparam logic [15:0] WAKE_END = 16'(WAKE_USED - 1);
  // half periods of the spread boost clock, 0.8 to 4 MHz around 2 MHz
  localparam int HALF_AVG = (`CLOCK_MHZ * 1000) / (2 * `BOOST_AVG_KHZ);
  localparam int HALF_MIN = (`CLOCK_MHZ * 1000) / (2 * `BOOST_MAX_KHZ);
  localparam int HALF_MAX = (`CLOCK_MHZ * 1000) / (2 * `BOOST_MIN_KHZ);
  localparam logic [7:0] HALF_AVG_C = 8'(HALF_AVG);
  localparam logic [7:0] HALF_MIN_C = 8'(HALF_MIN);
  localparam logic [7:0] HALF_MAX_C = 8'(HALF_MAX);

  tuner_bias_pkg::state_type s_q;
  tuner_bias_pkg::state_type s_d;

  // default register image, used by every power-on or commanded reset
  function automatic tuner_bias_pkg::regs_type defaultRegs();
    tuner_bias_pkg::regs_type r;
    r             = '0;
    r.boostLevel  = `RST_BOOST_LEVEL;
    r.enableMask  = `RST_ENABLE_MASK;
    r.powerSelect = `PWR_STARTUP;
    return r;
  endfunction

  // decode a committed frame into the register image
  function automatic tuner_bias_pkg::regs_type writeReg(
    input tuner_bias_pkg::regs_type r,
    input logic [4:0]               addr,
    input logic [15:0]              data
  );
    tuner_bias_pkg::regs_type n;
    n = r;
    if (addr == `ADDR_DAC_CB) begin
      n.codes.code2 = data[7:0];
    end else if (addr == `ADDR_DAC_BA) begin
      n.codes.code1 = data[15:8];
      n.codes.code0 = data[7:0];
    end else if (addr == `ADDR_DAC_FE) begin
      n.codes.code5 = data[7:0];
    end else if (addr == `ADDR_DAC_ED) begin
      n.codes.code4 = data[15:8];
      n.codes.code3 = data[7:0];
    end else if (addr == `ADDR_CONTROL) begin
      n.powerSelect = data[13:12];
      n.boostLevel  = data[11:8];
      n.enableMask  = data[5:0];
    end
    return n;
  endfunction

  logic        railUp;
  logic        clkRise;
  logic        csRise;
  logic        csFall;
  logic [29:0] frame;
  logic        frameOk;
  logic        resetRegs;

  // next state of the whole block
  always_comb begin
    s_d = s_q;
    // two flops on every pin, third stage on clock, select and rail; edges found on clock and select only
    s_d.rail  = {s_q.rail[1:0], ioRailLevel};
    s_d.sclk  = {s_q.sclk[1:0], serialClk};
    s_d.csel  = {s_q.csel[1:0], chipSelect};
    s_d.sdata = {s_q.sdata[0], serialData};
    s_d.cmp   = {s_q.cmp[0], railBelowReference};
    railUp  = s_q.rail[1];
    clkRise = s_q.sclk[1] & ~s_q.sclk[2];
    csRise  = s_q.csel[1] & ~s_q.csel[2];
    csFall  = ~s_q.csel[1] & s_q.csel[2];
    frame   = s_q.shift[29:0];
    frameOk = 1'b0;
    resetRegs = 1'b0;

    // serial shifter, msb first; length counted while select high
    // a clock edge seen together with the select edge is the first bit
    if (!railUp || csRise) begin
      s_d.shift    = '0;
      s_d.count    = '0;
      s_d.overflow = 1'b0;
    end
    if (railUp && s_q.csel[1] && clkRise) begin
      s_d.shift = {s_d.shift[30:0], s_q.sdata[1]};
      if (s_d.count == 7'h7f) begin
        s_d.overflow = 1'b1;
      end else begin
        s_d.count = s_d.count + 7'h01;
      end
    end

    // per frame length check; 32-bit frames must carry the header
    if (csFall && !s_q.overflow) begin
      if (s_q.count == {1'b0, `FRAME_SHORT}) begin
        frameOk = 1'b1;
      end else if (s_q.count == {1'b0, `FRAME_LONG} &&
                   s_q.shift[31:29] == `HEADER_LONG) begin
        frameOk = 1'b1;
      end
    end
    // write bit low and matching device field; no read path exists
    if (frameOk && (frame[29] || frame[28:21] != `DEVICE_ID_FIELD)) begin
      frameOk = 1'b0;
    end

    // mode machine
    case (s_q.mode)
      tuner_bias_pkg::MODE_SHUTDOWN: begin
        s_d.regs      = defaultRegs();
        s_d.wakeCount = '0;
        if (railUp) begin
          s_d.mode = tuner_bias_pkg::MODE_STARTUP;
        end
      end
      tuner_bias_pkg::MODE_STARTUP: begin
        s_d.regs = defaultRegs();
        if (s_q.wakeCount == WAKE_END) begin
          s_d.mode = tuner_bias_pkg::MODE_ACTIVE;
          s_d.regs.powerSelect = `PWR_ACTIVE;
        end else begin
          s_d.wakeCount = s_q.wakeCount + 16'h0001;
        end
      end
      tuner_bias_pkg::MODE_ACTIVE,
      tuner_bias_pkg::MODE_LOWPOWER: begin
        if (frameOk) begin
          s_d.regs = writeReg(s_q.regs, frame[4:0], frame[20:5]);
        end
        if (s_d.regs.powerSelect == `PWR_STARTUP) begin
          resetRegs = 1'b1;
        end
        if (resetRegs) begin
          s_d.mode      = tuner_bias_pkg::MODE_STARTUP;
          s_d.wakeCount = '0;
          s_d.regs      = defaultRegs();
        end else if (s_d.regs.powerSelect == `PWR_LOW) begin
          s_d.mode = tuner_bias_pkg::MODE_LOWPOWER;
        end else begin
          s_d.mode = tuner_bias_pkg::MODE_ACTIVE;
        end
      end
      default: begin
        s_d.mode = tuner_bias_pkg::MODE_SHUTDOWN;
      end
    endcase
    // rail low wins over everything
    if (!railUp) begin
      s_d.mode = tuner_bias_pkg::MODE_SHUTDOWN;
      s_d.regs = defaultRegs();
    end

    // boost runs in startup and active only, hysteresis from comparator
    s_d.boostRun = s_q.cmp[1] &&
      (s_q.mode == tuner_bias_pkg::MODE_STARTUP ||
       s_q.mode == tuner_bias_pkg::MODE_ACTIVE);

    // spread clock: half period walks 19..33 cycles around the average, inside the min..max clamps
    s_d.lfsr = {s_q.lfsr[2:0], s_q.lfsr[3] ^ s_q.lfsr[2]};
    if (!s_q.boostRun) begin
      s_d.boostDiv = '0;
      s_d.boostClk = 1'b0;
    end else if (s_q.boostDiv == '0) begin
      s_d.boostClk = ~s_q.boostClk;
      if (s_q.lfsr[3]) begin
        s_d.boostDiv = HALF_AVG_C + {5'h00, s_q.lfsr[2:0]} <= HALF_MAX_C ?
          HALF_AVG_C + {5'h00, s_q.lfsr[2:0]} : HALF_MAX_C;
      end else begin
        s_d.boostDiv = HALF_AVG_C - {5'h00, s_q.lfsr[2:0]} >= HALF_MIN_C ?
          HALF_AVG_C - {5'h00, s_q.lfsr[2:0]} : HALF_MIN_C;
      end
    end else begin
      s_d.boostDiv = s_q.boostDiv - 8'h01;
    end

    // outputs drive only in active mode with their enable bit
    if (s_q.mode == tuner_bias_pkg::MODE_ACTIVE) begin
      s_d.driveOn = s_q.regs.enableMask;
    end else begin
      s_d.driveOn = '0;
    end
    s_d.outCodes   = s_q.regs.codes;
    s_d.powerState = s_q.regs.powerSelect;
  end

  // single state register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q          <= '0;
      s_q.mode     <= tuner_bias_pkg::MODE_SHUTDOWN;
      s_q.lfsr     <= 4'h1;
      s_q.regs.boostLevel  <= `RST_BOOST_LEVEL;
      s_q.regs.powerSelect <= `PWR_STARTUP;
      s_q.powerState       <= `PWR_STARTUP;
    end else begin
      s_q <= s_d;
    end
  end

  assign boostEnable       = s_q.boostRun;
  assign boostSwitchClk    = s_q.boostClk;
  assign boostLevelCode    = s_q.regs.boostLevel;
  assign outputDriveEnable = s_q.driveOn;
  assign outputCodes       = s_q.outCodes;
  assign powerStateCommand = s_q.powerState;
endmodule // tuner_bias_power_and_serial_ctrl
